// ==== logic/README_unused.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== logic/sdct_consts.svh ====
`ifndef SDCT_CONSTS_SVH
`define SDCT_CONSTS_SVH

// Clock and conversion helpers: minimums round up, maximums round down
`define SDCT_CLK_PERIOD_PS 10000
`define SDCT_CYC_MIN(t) (((t) + `SDCT_CLK_PERIOD_PS - 1) / `SDCT_CLK_PERIOD_PS)
`define SDCT_CYC_MAX(t) ((t) / `SDCT_CLK_PERIOD_PS)
`define SDCT_MAX(a, b) (((a) > (b)) ? (a) : (b))

// CAS latency and the least clock period it allows
`define SDCT_CAS_LATENCY 2
`define SDCT_T_CK_CL2_PS 10000

// Array timing limits in picoseconds, SDCT_XSR_MIN_CLKS and the last two in clocks or counts (slowest grade, safe for all)
`define SDCT_T_RAS_MIN_PS 42000
`define SDCT_T_RAS_MAX_PS 120000000
`define SDCT_T_RC_PS 70000
`define SDCT_T_RFC_PS 70000
`define SDCT_T_RCD_PS 20000
`define SDCT_T_RP_PS 20000
`define SDCT_T_RRD_PS 14000
`define SDCT_T_WR_ADD_PS 7000
`define SDCT_T_WR_MAN_PS 14000
`define SDCT_T_XSR_PS 70000
`define SDCT_XSR_MIN_CLKS 2
`define SDCT_T_POWERUP_PS 100000000
`define SDCT_MRD_CYC 2
`define SDCT_INIT_REFS 2

// Refresh interval per row
`define SDCT_REF_ROWS 4096
`define SDCT_T_REF_STD_MS 64
`define SDCT_T_REF_AUTO_MS 16
`define SDCT_NS_PER_MS 1000000
`define SDCT_PS_PER_NS 1000

// Derived cycle counts
`define SDCT_RAS_MIN_CYC `SDCT_CYC_MIN(`SDCT_T_RAS_MIN_PS)
`define SDCT_RAS_MAX_CYC `SDCT_CYC_MAX(`SDCT_T_RAS_MAX_PS)
`define SDCT_RC_CYC `SDCT_CYC_MIN(`SDCT_T_RC_PS)
`define SDCT_RFC_CYC `SDCT_CYC_MIN(`SDCT_T_RFC_PS)
`define SDCT_RCD_CYC `SDCT_CYC_MIN(`SDCT_T_RCD_PS)
`define SDCT_RP_CYC `SDCT_CYC_MIN(`SDCT_T_RP_PS)
`define SDCT_RRD_CYC `SDCT_CYC_MIN(`SDCT_T_RRD_PS)
`define SDCT_WR_CYC `SDCT_MAX(1 + `SDCT_CYC_MIN(`SDCT_T_WR_ADD_PS), `SDCT_CYC_MIN(`SDCT_T_WR_MAN_PS))
`define SDCT_XSR_CYC `SDCT_MAX(`SDCT_CYC_MIN(`SDCT_T_XSR_PS), `SDCT_XSR_MIN_CLKS)
`define SDCT_POWERUP_CYC `SDCT_CYC_MIN(`SDCT_T_POWERUP_PS)
`define SDCT_REF_STD_CYC `SDCT_CYC_MAX(`SDCT_T_REF_STD_MS * `SDCT_NS_PER_MS / `SDCT_REF_ROWS * `SDCT_PS_PER_NS)
`define SDCT_REF_AUTO_CYC `SDCT_CYC_MAX(`SDCT_T_REF_AUTO_MS * `SDCT_NS_PER_MS / `SDCT_REF_ROWS * `SDCT_PS_PER_NS)

// Mode word and address bits, and the refresh debt limit
`define SDCT_MODE_CL_LSB 4
`define SDCT_AP_BIT 10
`define SDCT_REF_DEBT_MAX 2

`endif

// ==== logic/sdct_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sdct_consts.svh"

module sdct_ctrl
  import sdct_pkg::*;
#(
  parameter int POWERUP_CYC = `SDCT_POWERUP_CYC,
  parameter int RAS_MAX_CYC = `SDCT_RAS_MAX_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // User request
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [1:0]  req_bank,
  input  wire logic [10:0] req_row,
  input  wire logic [7:0]  req_col,
  input  wire logic [31:0] req_wdata,
  output logic             req_ready,
  // Read return
  output logic             rd_valid,
  output logic [31:0]      rd_data,
  // Mode and status
  input  wire logic        sr_req,
  input  wire logic        auto_temp,
  output logic             init_done,
  output logic             self_ref_active,
  // Memory pins
  output logic             sd_cke,
  output logic             sd_cs_n,
  output logic             sd_ras_n,
  output logic             sd_cas_n,
  output logic             sd_we_n,
  output logic [1:0]       sd_ba,
  output logic [10:0]      sd_addr,
  output logic [3:0]       sd_dqm,
  output logic [31:0]      sd_dq_out,
  output logic             sd_dq_oe,
  input  wire logic [31:0] sd_dq_in
);

  localparam int CL = `SDCT_CAS_LATENCY;

  sdct_state_e state_r, state_nxt, ret_r, ret_nxt;
  sdct_cmd_e   cmd_r, cmd_nxt;
  logic        cke_r, cke_nxt, oe_r, oe_nxt, ready_r, init_r, init_nxt;
  logic [10:0] addr_r, addr_nxt;
  logic [1:0]  ba_r, ba_nxt, init_refs_r, init_refs_nxt, debt_r, debt_nxt;
  logic        wr_r, sr_act_r;
  logic [1:0]  bank_r;
  logic [10:0] row_r;
  logic [7:0]  col_r;
  logic [31:0] wdata_r, dq_out_r, rd_data_r;
  logic [CL:0] rd_pipe_r;
  logic        rd_valid_r;
  sdct_cnt_t   ref_cnt_r, wait_val;
  logic        wait_ld, wait_done, ras_done, wr_done, rrd_done;
  logic [3:0]  rc_done;

  // Decoded conditions
  wire accept    = (state_r == SDCT_S_IDLE) && req_valid && ready_r;
  wire can_act   = rc_done[bank_r] && rrd_done;
  wire all_rc    = &rc_done;
  wire issue_act = (cmd_nxt == SDCT_CMD_ACT);
  wire issue_wr  = (cmd_nxt == SDCT_CMD_WRITE);
  wire issue_rd  = (cmd_nxt == SDCT_CMD_READ);
  // Gated by init so the cleared counter after reset does not raise a false debt
  wire ref_tick  = init_r && (ref_cnt_r == '0);
  wire ref_issue = (state_r == SDCT_S_IDLE) && (cmd_nxt == SDCT_CMD_REF) && cke_nxt;
  wire sr_exit   = (state_r == SDCT_S_SELF) && !sr_req;
  wire [10:0] mode_word = 11'(CL << `SDCT_MODE_CL_LSB);
  wire sdct_cnt_t ref_load = auto_temp ? sdct_cnt_t'(`SDCT_REF_AUTO_CYC - 1)
                                       : sdct_cnt_t'(`SDCT_REF_STD_CYC - 1);

  // Refresh debt: a new tick wins over a refresh or self refresh clearing it
  always_comb begin
    debt_nxt = debt_r;
    if (sr_exit) begin
      debt_nxt = 2'(ref_tick);
    end else if (ref_tick && !ref_issue && debt_r != 2'(`SDCT_REF_DEBT_MAX)) begin
      debt_nxt = debt_r + 2'h1;
    end else if (!ref_tick && ref_issue) begin
      debt_nxt = debt_r - 2'h1;
    end
  end

  // Sequencer; waits reload the gap timer with cycles minus two
  always_comb begin
    state_nxt     = state_r;
    ret_nxt       = ret_r;
    cmd_nxt       = SDCT_CMD_NOP;
    cke_nxt       = cke_r;
    oe_nxt        = 1'b0;
    addr_nxt      = addr_r;
    ba_nxt        = ba_r;
    init_nxt      = init_r;
    init_refs_nxt = init_refs_r;
    wait_ld       = 1'b0;
    wait_val      = '0;
    unique case (state_r)
      SDCT_S_PWR: begin
        cke_nxt   = 1'b1;
        wait_ld   = 1'b1;
        wait_val  = sdct_cnt_t'(POWERUP_CYC - 2);
        ret_nxt   = SDCT_S_PRE_ALL;
        state_nxt = SDCT_S_WAIT;
      end
      SDCT_S_PRE_ALL: begin
        cmd_nxt   = SDCT_CMD_PRE;
        addr_nxt  = 11'h400;
        wait_ld   = 1'b1;
        wait_val  = sdct_cnt_t'(`SDCT_RP_CYC - 2);
        ret_nxt   = SDCT_S_INIT_REF;
        state_nxt = SDCT_S_WAIT;
      end
      SDCT_S_INIT_REF: begin
        cmd_nxt       = SDCT_CMD_REF;
        init_refs_nxt = init_refs_r + 2'h1;
        wait_ld       = 1'b1;
        wait_val      = sdct_cnt_t'(`SDCT_RFC_CYC - 2);
        ret_nxt       = (init_refs_nxt == 2'(`SDCT_INIT_REFS)) ? SDCT_S_MRS : SDCT_S_INIT_REF;
        state_nxt     = SDCT_S_WAIT;
      end
      SDCT_S_MRS: begin
        cmd_nxt   = SDCT_CMD_MRS;
        addr_nxt  = mode_word;
        ba_nxt    = 2'h0;
        init_nxt  = 1'b1;
        wait_ld   = 1'b1;
        wait_val  = sdct_cnt_t'(`SDCT_MRD_CYC - 2);
        ret_nxt   = SDCT_S_IDLE;
        state_nxt = SDCT_S_WAIT;
      end
      SDCT_S_IDLE: begin
        if (accept) begin
          state_nxt = SDCT_S_ACT;
        end else if (debt_r != 2'h0 && all_rc) begin
          cmd_nxt   = SDCT_CMD_REF;
          wait_ld   = 1'b1;
          wait_val  = sdct_cnt_t'(`SDCT_RFC_CYC - 2);
          ret_nxt   = SDCT_S_IDLE;
          state_nxt = SDCT_S_WAIT;
        end else if (sr_req && !auto_temp && debt_r == 2'h0 && all_rc) begin
          cmd_nxt   = SDCT_CMD_REF;
          cke_nxt   = 1'b0;
          state_nxt = SDCT_S_SELF;
        end
      end
      SDCT_S_ACT: begin
        if (can_act) begin
          cmd_nxt   = SDCT_CMD_ACT;
          ba_nxt    = bank_r;
          addr_nxt  = row_r;
          wait_ld   = 1'b1;
          wait_val  = sdct_cnt_t'(`SDCT_RCD_CYC - 2);
          ret_nxt   = SDCT_S_RW;
          state_nxt = SDCT_S_WAIT;
        end
      end
      SDCT_S_RW: begin
        cmd_nxt   = wr_r ? SDCT_CMD_WRITE : SDCT_CMD_READ;
        addr_nxt  = {3'h0, col_r};
        oe_nxt    = wr_r;
        state_nxt = SDCT_S_PRE;
      end
      SDCT_S_PRE: begin
        if (ras_done && wr_done) begin
          cmd_nxt   = SDCT_CMD_PRE;
          addr_nxt  = 11'h000;
          wait_ld   = 1'b1;
          wait_val  = sdct_cnt_t'(`SDCT_RP_CYC - 2);
          ret_nxt   = SDCT_S_IDLE;
          state_nxt = SDCT_S_WAIT;
        end
      end
      SDCT_S_SELF: begin
        if (!sr_req) begin
          cke_nxt   = 1'b1;
          wait_ld   = 1'b1;
          wait_val  = sdct_cnt_t'(`SDCT_XSR_CYC - 2);
          ret_nxt   = SDCT_S_IDLE;
          state_nxt = SDCT_S_WAIT;
        end
      end
      SDCT_S_WAIT: begin
        if (wait_done) begin
          state_nxt = ret_r;
        end
      end
    endcase
  end

  // Gap timers; per-bank row cycle timers in one loop
  sdct_gap_timer u_wait (.sys_clk(sys_clk), .rst_n(rst_n), .load(wait_ld),
                         .load_val(wait_val), .done(wait_done));
  sdct_gap_timer u_ras (.sys_clk(sys_clk), .rst_n(rst_n), .load(issue_act),
                        .load_val(sdct_cnt_t'(`SDCT_RAS_MIN_CYC - 1)), .done(ras_done));
  sdct_gap_timer u_wr (.sys_clk(sys_clk), .rst_n(rst_n), .load(issue_wr),
                       .load_val(sdct_cnt_t'(`SDCT_WR_CYC - 1)), .done(wr_done));
  sdct_gap_timer u_rrd (.sys_clk(sys_clk), .rst_n(rst_n), .load(issue_act),
                        .load_val(sdct_cnt_t'(`SDCT_RRD_CYC - 1)), .done(rrd_done));
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_bank
      sdct_gap_timer u_rc (.sys_clk(sys_clk), .rst_n(rst_n),
                           .load(issue_act && (bank_r == 2'(gb))),
                           .load_val(sdct_cnt_t'(`SDCT_RC_CYC - 1)), .done(rc_done[gb]));
    end
  endgenerate

  // State, pins and handshake; ready is predicted for the next cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r     <= SDCT_S_PWR;
      ret_r       <= SDCT_S_PWR;
      cmd_r       <= SDCT_CMD_NOP;
      cke_r       <= 1'b0;
      oe_r        <= 1'b0;
      addr_r      <= 11'h000;
      ba_r        <= 2'h0;
      init_r      <= 1'b0;
      init_refs_r <= 2'h0;
      debt_r      <= 2'h0;
      ready_r     <= 1'b0;
      sr_act_r    <= 1'b0;
      ref_cnt_r   <= '0;
    end else begin
      state_r     <= state_nxt;
      ret_r       <= ret_nxt;
      cmd_r       <= cmd_nxt;
      cke_r       <= cke_nxt;
      oe_r        <= oe_nxt;
      addr_r      <= addr_nxt;
      ba_r        <= ba_nxt;
      init_r      <= init_nxt;
      init_refs_r <= init_refs_nxt;
      debt_r      <= debt_nxt;
      ready_r     <= (state_nxt == SDCT_S_IDLE) && (debt_nxt == 2'h0) && !accept;
      sr_act_r    <= !cke_nxt && init_nxt;
      // Clamp on a switch to the shorter interval, else the old count overruns it
      ref_cnt_r   <= (ref_tick || !init_r || ref_cnt_r > ref_load) ? ref_load
                                                                  : ref_cnt_r - 14'h0001;
    end
  end

  // Request capture and read return; read data comes back CL+1 edges on
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_r       <= 1'b0;
      bank_r     <= 2'h0;
      row_r      <= 11'h000;
      col_r      <= 8'h00;
      wdata_r    <= 32'h0000_0000;
      dq_out_r   <= 32'h0000_0000;
      rd_pipe_r  <= '0;
      rd_valid_r <= 1'b0;
      rd_data_r  <= 32'h0000_0000;
    end else begin
      if (accept) begin
        wr_r    <= req_write;
        bank_r  <= req_bank;
        row_r   <= req_row;
        col_r   <= req_col;
        wdata_r <= req_wdata;
      end
      dq_out_r   <= issue_wr ? wdata_r : dq_out_r;
      rd_pipe_r  <= {rd_pipe_r[CL-1:0], issue_rd};
      rd_valid_r <= rd_pipe_r[CL];
      rd_data_r  <= rd_pipe_r[CL] ? sd_dq_in : rd_data_r;
    end
  end

  // Output drive
  assign req_ready       = ready_r;
  assign rd_valid        = rd_valid_r;
  assign rd_data         = rd_data_r;
  assign init_done       = init_r;
  assign self_ref_active = sr_act_r;
  assign sd_cke          = cke_r;
  assign sd_cs_n         = 1'b0;
  assign {sd_ras_n, sd_cas_n, sd_we_n} = cmd_r;
  assign sd_ba           = ba_r;
  assign sd_addr         = addr_r;
  assign sd_dqm          = 4'h0;
  assign sd_dq_out       = dq_out_r;
  assign sd_dq_oe        = oe_r;

  // Helpers for assertions: cycles since each activate, precharge and refresh seen on the pins
  logic [7:0]  since_act_r, since_pre_r, since_ref_r;
  logic [1:0]  last_ba_r;
  logic [13:0] up_cnt_r, open_cnt_r;
  wire p_act = cke_r && cmd_r == SDCT_CMD_ACT;
  wire p_pre = cke_r && cmd_r == SDCT_CMD_PRE;
  wire p_ref = cke_r && cmd_r == SDCT_CMD_REF;
  wire p_wr  = cmd_r == SDCT_CMD_WRITE;
  wire p_rd  = cmd_r == SDCT_CMD_READ;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      since_act_r <= 8'hff;
      since_pre_r <= 8'hff;
      since_ref_r <= 8'hff;
      last_ba_r   <= 2'h0;
      up_cnt_r    <= 14'h0000;
      open_cnt_r  <= 14'h0000;
    end else begin
      since_act_r <= p_act ? 8'h01 : since_act_r + 8'(since_act_r != 8'hff);
      since_pre_r <= p_pre ? 8'h01 : since_pre_r + 8'(since_pre_r != 8'hff);
      since_ref_r <= p_ref ? 8'h01 : since_ref_r + 8'(since_ref_r != 8'hff);
      last_ba_r   <= p_act ? ba_r : last_ba_r;
      up_cnt_r    <= up_cnt_r + 14'(up_cnt_r != 14'h3fff);
      open_cnt_r  <= p_act ? 14'h0001 : (p_pre ? 14'h0000 : open_cnt_r + 14'(open_cnt_r != 14'h0));
    end
  end

  sequence seq_write_issued;
    p_wr;
  endsequence
  sequence seq_no_pre_gap;
    !p_pre;
  endsequence
  sequence seq_cke_rise;
    !$past(cke_r) && cke_r && init_r;
  endsequence

  AST_CLK_PERIOD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    `SDCT_CLK_PERIOD_PS >= `SDCT_T_CK_CL2_PS) else $error("clock too fast for CAS latency");
  AST_RAS_MIN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    p_act |=> !p_pre [*4]) else $error("precharge before row active time");
  AST_RAS_MAX: assert property (@(posedge sys_clk) disable iff (!rst_n)
    open_cnt_r < 14'(RAS_MAX_CYC)) else $error("row open past maximum");
  AST_RC: assert property (@(posedge sys_clk) disable iff (!rst_n)
    p_act && ba_r == last_ba_r |-> since_act_r >= 8'(`SDCT_RC_CYC))
    else $error("same bank activate too soon");
  AST_RFC: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (p_act || p_ref || p_pre) |-> since_ref_r >= 8'(`SDCT_RFC_CYC))
    else $error("command too soon after refresh");
  AST_RCD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (p_wr || p_rd) |-> since_act_r >= 8'(`SDCT_RCD_CYC)) else $error("column too soon");
  AST_RP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    p_act |-> since_pre_r >= 8'(`SDCT_RP_CYC)) else $error("activate too soon after precharge");
  AST_RRD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    p_act |=> !p_act) else $error("activates too close");
  AST_WR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seq_write_issued |=> seq_no_pre_gap) else $error("precharge inside write recovery");
  AST_XSR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seq_cke_rise |-> !p_act [*7]) else $error("activate inside self refresh exit");
  AST_PWRUP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    p_pre && !init_r |-> up_cnt_r >= 14'(POWERUP_CYC - 1)) else $error("power-up pause short");
  AST_REF_SERVE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == SDCT_S_IDLE && debt_r != 2'h0 && all_rc && !accept |=> p_ref)
    else $error("pending refresh not issued");
  AST_RD_LAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    p_rd |-> ##3 rd_valid_r) else $error("read data not returned");

endmodule

`default_nettype wire

// ==== logic/sdct_gap_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module sdct_gap_timer
  import sdct_pkg::*;
(
  // Clock and reset
  input  wire logic      sys_clk,
  input  wire logic      rst_n,
  // Load and status
  input  wire logic      load,
  input  wire sdct_cnt_t load_val,
  output logic           done
);

  sdct_cnt_t count_r;

  // Down counter that parks at zero; a load restarts it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (load) begin
      count_r <= load_val;
    end else if (count_r != '0) begin
      count_r <= count_r - 14'h0001;
    end
  end

  assign done = (count_r == '0);

endmodule

`default_nettype wire

// ==== logic/sdct_pkg.sv ====
package sdct_pkg;

  // Counter width shared by all gap timers
  typedef logic [13:0] sdct_cnt_t;

  // Command code on {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    SDCT_CMD_MRS   = 3'h0,
    SDCT_CMD_REF   = 3'h1,
    SDCT_CMD_PRE   = 3'h2,
    SDCT_CMD_ACT   = 3'h3,
    SDCT_CMD_WRITE = 3'h4,
    SDCT_CMD_READ  = 3'h5,
    SDCT_CMD_NOP   = 3'h7
  } sdct_cmd_e;

  // Sequencer states
  typedef enum logic [3:0] {
    SDCT_S_PWR      = 4'b0000,
    SDCT_S_PRE_ALL  = 4'b0001,
    SDCT_S_INIT_REF = 4'b0010,
    SDCT_S_MRS      = 4'b0011,
    SDCT_S_IDLE     = 4'b0100,
    SDCT_S_ACT      = 4'b0101,
    SDCT_S_RW       = 4'b0110,
    SDCT_S_PRE      = 4'b0111,
    SDCT_S_SELF     = 4'b1000,
    SDCT_S_WAIT     = 4'b1001
  } sdct_state_e;

endpackage

// ==== tb/sdct_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sdct_consts.svh"

// Memory device: keeps words, answers reads, counts spacing faults
module sdct_mem_model
  import sdct_pkg::*;
#(
  parameter int POWERUP_CYC = 20
) (
  // Clock and part type
  input  wire logic        sys_clk,
  input  wire logic        auto_temp,
  // Command pins
  input  wire logic        sd_cke,
  input  wire logic        sd_cs_n,
  input  wire logic [2:0]  sd_cmd,
  input  wire logic [1:0]  sd_ba,
  input  wire logic [10:0] sd_addr,
  // Data pins
  input  wire logic [31:0] sd_dq_out,
  input  wire logic        sd_dq_oe,
  output logic [31:0]      sd_dq_in,
  // Fault count
  output int               viol
);
  logic [31:0] mem [int];
  logic [31:0] rd_word;
  logic        rd_due = 1'b0;
  logic        sref = 1'b0;
  logic        auto_prev = 1'b0;
  logic [3:0]  open_r = 4'h0;
  logic [10:0] row_r [4];
  int cyc = 0, pu = -1, refs = 0, key, gap, n_viol = 0;
  int last_ref = -999, last_act = -999, sr_exit = -999;
  int act_t [4] = '{default: -999};
  int pre_t [4] = '{default: -999};
  int wr_t [4] = '{default: -999};

  assign viol = n_viol;
  initial sd_dq_in = '0;

  task automatic flag(input logic bad);
    if (bad) n_viol++;
  endtask

  // Sample on the rising edge; minimums are cycle counts rounded up
  always @(posedge sys_clk) begin
    cyc++;
    gap = auto_temp ? `SDCT_REF_AUTO_CYC : `SDCT_REF_STD_CYC;
    // Word valid one cycle; then lines toggle so no stale value can match
    sd_dq_in <= rd_due ? rd_word : ~sd_dq_in;
    rd_due = 1'b0;
    if (auto_temp != auto_prev) last_ref = cyc;
    auto_prev = auto_temp;
    if (!sd_cs_n && !sd_cke && pu >= 0 && sd_cmd == SDCT_CMD_REF) sref = 1'b1;
    // Clock enable low outside self refresh means the part restarts
    if (!sd_cke && !sref) begin
      pu = -1;
      refs = 0;
    end else if (pu < 0) begin
      pu = cyc;
    end
    if (sref && sd_cke) begin
      sref = 1'b0;
      sr_exit = cyc;
      last_ref = cyc;
    end
    if (!sd_cs_n && sd_cmd != SDCT_CMD_NOP && pu >= 0) flag(cyc - pu < POWERUP_CYC - 2);
    if (!sd_cs_n && sd_cke && !sref) begin
      case (sd_cmd)
        SDCT_CMD_ACT: begin
          flag(open_r[sd_ba]);
          flag(cyc - act_t[sd_ba] < `SDCT_RC_CYC);
          flag(cyc - last_act < `SDCT_RRD_CYC);
          flag(cyc - pre_t[sd_ba] < `SDCT_RP_CYC);
          flag(cyc - last_ref < `SDCT_RFC_CYC);
          flag(cyc - sr_exit < `SDCT_XSR_CYC);
          flag(refs < 2);
          act_t[sd_ba] = cyc;
          last_act = cyc;
          open_r[sd_ba] = 1'b1;
          row_r[sd_ba] = sd_addr;
        end
        SDCT_CMD_READ, SDCT_CMD_WRITE: begin
          flag(!open_r[sd_ba] || cyc - act_t[sd_ba] < `SDCT_RCD_CYC);
          key = int'({sd_ba, row_r[sd_ba], sd_addr[7:0]});
          if (sd_cmd == SDCT_CMD_WRITE) begin
            flag(!sd_dq_oe);
            mem[key] = sd_dq_out;
            wr_t[sd_ba] = cyc;
          end else begin
            rd_word = mem.exists(key) ? mem[key] : ~sd_dq_in;
            rd_due = 1'b1;
          end
        end
        SDCT_CMD_PRE: for (int b = 0; b < 4; b++) begin
          if (sd_addr[`SDCT_AP_BIT] || int'(sd_ba) == b) begin
            flag(open_r[b] && cyc - act_t[b] < `SDCT_RAS_MIN_CYC);
            flag(open_r[b] && cyc - act_t[b] > `SDCT_RAS_MAX_CYC);
            flag(cyc - wr_t[b] < `SDCT_WR_CYC);
            open_r[b] = 1'b0;
            pre_t[b] = cyc;
          end
        end
        SDCT_CMD_REF: begin
          flag(open_r != 4'h0 || cyc - last_ref < `SDCT_RFC_CYC);
          flag(refs >= 2 && cyc - last_ref > 2 * gap);
          refs++;
          last_ref = cyc;
        end
        default: ;
      endcase
    end
  end
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import sdct_pkg::*;
;
  localparam int PU_CYC = 20;
  localparam int STD_GAP = 64_000_000 / 4096 / 10;
  localparam int AUTO_GAP = 16_000_000 / 4096 / 10;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        req_valid = 1'b0, req_write = 1'b0, sr_req = 1'b0, auto_temp = 1'b0;
  logic [1:0]  req_bank = '0;
  logic [10:0] req_row = '0;
  logic [7:0]  req_col = '0;
  logic [31:0] req_wdata = '0;
  logic        req_ready, rd_valid, init_done, self_ref_active, sd_dq_oe;
  logic        sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n;
  logic [1:0]  sd_ba;
  logic [10:0] sd_addr;
  logic [31:0] rd_data, sd_dq_out, sd_dq_in;
  logic [31:0] lfsr = 32'h0000_a500;
  logic [31:0] ref_mem [int];
  logic [31:0] exp_q [$];
  int          viol, n_fail = 0, comparisons = 0, cycles = 0, n_refs = 0;

  always #5 sys_clk = ~sys_clk;

  sdct_ctrl #(.POWERUP_CYC(PU_CYC)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
    .req_bank(req_bank), .req_row(req_row), .req_col(req_col), .req_wdata(req_wdata),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .sr_req(sr_req),
    .auto_temp(auto_temp), .init_done(init_done), .self_ref_active(self_ref_active),
    .sd_cke(sd_cke), .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n),
    .sd_we_n(sd_we_n), .sd_ba(sd_ba), .sd_addr(sd_addr), .sd_dqm(),
    .sd_dq_out(sd_dq_out), .sd_dq_oe(sd_dq_oe), .sd_dq_in(sd_dq_in));

  sdct_mem_model #(.POWERUP_CYC(PU_CYC)) i_mem (
    .sys_clk(sys_clk), .auto_temp(auto_temp), .sd_cke(sd_cke), .sd_cs_n(sd_cs_n),
    .sd_cmd({sd_ras_n, sd_cas_n, sd_we_n}), .sd_ba(sd_ba), .sd_addr(sd_addr),
    .sd_dq_out(sd_dq_out), .sd_dq_oe(sd_dq_oe), .sd_dq_in(sd_dq_in), .viol(viol));

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'h8020_0003) : (x >> 1);
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bounded wait on init_done (sel 0) or self_ref_active (sel 1)
  task automatic wait_sig(input logic sel, input int n);
    while (((sel ? self_ref_active : init_done) !== 1'b1) && n > 0) begin
      @(posedge sys_clk);
      #1;
      n--;
    end
    check(sel ? "self_ref_wait" : "init_wait", 1, n > 0);
  endtask

  // Request held until the edge where ready is seen high, then dropped
  task automatic do_req(input logic w, input int k, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge sys_clk);
    #1;
    req_valid = 1'b1;
    req_write = w;
    {req_bank, req_row, req_col} = k[20:0];
    req_wdata = data;
    while (req_ready !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 400) begin
        n_fail++;
        report_and_stop();
      end
    end
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
  endtask

  // Few rows and columns per bank, so same-bank reopens come often
  task automatic traffic(input int n);
    int k;
    logic w;
    for (int i = 0; i < n; i++) begin
      lfsr = lfsr_next(lfsr);
      k = int'({lfsr[1:0], 9'h000, lfsr[3:2], 6'h00, lfsr[5:4]});
      w = !ref_mem.exists(k) || lfsr[6];
      lfsr = lfsr_next(lfsr);
      do_req(w, k, lfsr);
      if (w) ref_mem[k] = lfsr;
      else exp_q.push_back(ref_mem[k]);
    end
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    #1 rst_n = 1'b0;
    repeat (11) @(posedge sys_clk);
    @(negedge sys_clk);
    check("cke_in_reset", 0, sd_cke);
    check("cmd_in_reset", SDCT_CMD_NOP, {sd_ras_n, sd_cas_n, sd_we_n});
    check("ready_in_reset", 0, req_ready);
    @(posedge sys_clk);
    #1 rst_n = 1'b1;
  endtask

  // Idle stretch: refresh count must follow the per-row interval
  task automatic ref_pace(input int len, input int per);
    n_refs = 0;
    repeat (len) @(posedge sys_clk);
    check("ref_count", 1, n_refs >= len / per && n_refs <= len / per + 1);
  endtask

  // Outputs looked at on the falling edge, where they have settled
  always @(negedge sys_clk) begin
    if ({sd_ras_n, sd_cas_n, sd_we_n} === SDCT_CMD_REF && sd_cke === 1'b1) n_refs++;
    if (rd_valid === 1'b1 && exp_q.size() == 0) check("rd_unexpected", 0, 1);
    else if (rd_valid === 1'b1) check("rd_data", exp_q.pop_front(), rd_data);
  end

  // A hang counts as a mismatch
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 30000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    do_reset();
    wait_sig(0, 200 + PU_CYC);
    traffic(80);
    ref_pace(4000, STD_GAP);
    @(posedge sys_clk);
    #1 auto_temp = 1'b1;
    sr_req = 1'b1;
    repeat (500) @(posedge sys_clk);
    ref_pace(2000, AUTO_GAP);
    check("self_ref_on_auto", 0, self_ref_active);
    @(posedge sys_clk);
    #1 auto_temp = 1'b0;
    wait_sig(1, 3000);
    check("cke_self_ref", 0, sd_cke);
    repeat (200) @(posedge sys_clk);
    #1 sr_req = 1'b0;
    traffic(10);
    // Let the last access finish before the reset cuts it
    repeat (20) @(posedge sys_clk);
    check("self_ref_exit", 0, self_ref_active);
    do_reset();
    wait_sig(0, 200 + PU_CYC);
    traffic(20);
    repeat (20) @(posedge sys_clk);
    check("reads_pending", 0, exp_q.size());
    check("device_faults", 0, viol);
    report_and_stop();
  end
endmodule

`default_nettype wire
